// ===== hdl/erdaf_pkg.sv
package erdaf_pkg;

  // register word indexes on the register port
  localparam logic [9:0] REG_CONTROL    = 10'h000;
  localparam logic [9:0] REG_AR_CONTROL = 10'h001;
  localparam logic [9:0] REG_DMA_CONFIG = 10'h002;
  localparam logic [9:0] REG_EVENTS     = 10'h003;
  localparam logic [9:0] REG_POINTERS   = 10'h004;
  localparam logic [9:0] REG_BD_BASE    = 10'h200;
  localparam int         BD_SEL_BIT     = 9;

  // reset values
  localparam logic [15:0] AR_CONTROL_RESET = 16'h0000;
  localparam logic [1:0]  SPLIT_RESET      = 2'h0;

  // address_recognition_control fields
  localparam int AR_HASH_EN    = 15;
  localparam int AR_INDEX_EN   = 14;
  localparam int AR_GROUP_HI   = 13;
  localparam int AR_GROUP_LO   = 12;
  localparam int AR_INVERT     = 11;
  localparam int AR_ACCEPT_ALL = 10;
  localparam logic [15:0] AR_WRITABLE = 16'hfc00;

  // event register bits
  localparam int EV_NO_DESC  = 0;
  localparam int EV_RX_BUF   = 1;
  localparam int EV_RX_FRAME = 2;
  localparam int EV_TX_BUF   = 3;
  localparam int EV_WIDTH    = 4;

  // group address control encodings
  localparam logic [1:0] GROUP_NONE      = 2'h0;
  localparam logic [1:0] GROUP_BROADCAST = 2'h1;
  localparam logic [1:0] GROUP_MATCHED   = 2'h2;
  localparam logic [1:0] GROUP_ALL       = 2'h3;

  // reason codes placed above the table index
  localparam logic [1:0] REASON_MISS    = 2'h0;
  localparam logic [1:0] REASON_PERFECT = 2'h1;
  localparam logic [1:0] REASON_HASH    = 2'h2;
  localparam logic [1:0] REASON_GROUP   = 2'h3;

  // address table lines that turn into hash entries
  localparam logic [5:0] HASH_LINE_A = 6'h3e;
  localparam logic [5:0] HASH_LINE_B = 6'h3f;

  // descriptor pool
  localparam int         BD_COUNT     = 128;
  localparam logic [6:0] BD_LAST      = 7'h7f;
  localparam int         BD_WORDS     = 4;
  localparam logic [1:0] W_STATUS     = 2'h0;
  localparam logic [1:0] W_LENGTH     = 2'h1;
  localparam logic [1:0] W_PTR_HI     = 2'h2;
  localparam logic [1:0] W_PTR_LO     = 2'h3;

  // status word bits
  localparam int BD_OWN   = 15;
  localparam int BD_SWOWN = 14;
  localparam int BD_WRAP  = 13;
  localparam int BD_IRQ   = 12;
  localparam int BD_LAST_BIT  = 11;
  localparam int BD_FIRST = 10;
  localparam int BD_MISS  = 8;
  localparam int BD_LG    = 5;
  localparam int BD_NO    = 4;
  localparam int BD_SH    = 3;
  localparam int BD_CR    = 2;
  localparam int BD_OV    = 1;
  localparam int BD_CL    = 0;
  localparam int BD_UN    = 1;
  localparam logic [15:0] RX_KEEP_MASK = 16'h7000;
  localparam logic [15:0] TX_KEEP_MASK = 16'h7ffd;

  localparam logic [10:0] MAX_RX_BYTES = 11'd1520;

endpackage : erdaf_pkg

// ===== hdl/erdaf_core.sv
// Summary of operation
// - AR control writable only while disabled, resets zero
// - hash mode turns entries 62, 63 hash
// - index insertion writes index into pointer top
// - broadcast is multicast; group control gates multicast
// - invert bit accepts individual frames without perfect match
// - accept-all takes every frame
// - reserved low AR bits read zero
// - ownership bit cleared only after status written
// - disabled: descriptor pointers back to table starts; receive pointer held at 0 until enabled
// - split field divides pool between tables
// - tables are circular, wrap bit returns
// - transmit underrun: bad CRC, flag last descriptor
// - data without owned descriptor raises busy event
// - overrun flag zeroes other frame flags
// - frame flags only on last descriptor
// - aborted reception also closes the descriptor
// - interrupt bit sets buffer event when filled
// - miss flag when accepted only by accept-all
// - frames over 1520 bytes truncated, flagged
// - non-octet with CRC failure clears CRC flag
// - short flag zero; collision only if late
// - index fields on every descriptor of frame
// - frame start without buffer sets busy event
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none

module erdaf_core (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [9:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_dest_group,
  input  wire logic        rx_dest_broadcast,
  input  wire logic        rx_table_hit,
  input  wire logic [5:0]  rx_table_line,
  input  wire logic        rx_hash_hit,
  input  wire logic [5:0]  rx_hash_index,
  input  wire logic        rx_data_avail,
  input  wire logic [10:0] rx_frame_bytes,
  input  wire logic        rx_buf_full,
  input  wire logic [15:0] rx_buf_len,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_abort,
  input  wire logic        rx_nonoctet,
  input  wire logic        rx_crc_bad,
  input  wire logic        rx_late_coll,
  input  wire logic        rx_fifo_overflow,
  output logic             rx_frame_accept,
  output logic             rx_store_byte,
  output logic             rx_dma_ready,
  output logic      [31:0] rx_dma_addr,
  input  wire logic        tx_buf_done,
  input  wire logic        tx_underrun,
  output logic             tx_dma_ready,
  output logic      [31:0] tx_dma_addr,
  output logic             tx_bad_crc
);

  typedef enum logic [2:0] {
    ERDAF_IDLE = 3'b001,
    ERDAF_RECV = 3'b010,
    ERDAF_DROP = 3'b100
  } erdaf_rx_state_e;

  erdaf_rx_state_e rx_state;
  erdaf_rx_state_e next_rx_state;

  logic [15:0] bd_ram [0:erdaf_pkg::BD_COUNT*erdaf_pkg::BD_WORDS-1];
  logic        mac_global_enable;
  logic [15:0] ar_control;
  logic [1:0]  descriptor_split;
  logic [erdaf_pkg::EV_WIDTH-1:0] events;
  logic [6:0]  tx_ptr;
  logic [6:0]  rx_ptr;
  logic        rx_first;
  logic        tx_starved;
  logic [7:0]  frame_tag;
  logic        frame_miss;

  // register port decode
  wire sel_ctl = reg_addr == erdaf_pkg::REG_CONTROL;
  wire sel_ar  = reg_addr == erdaf_pkg::REG_AR_CONTROL;
  wire sel_dma = reg_addr == erdaf_pkg::REG_DMA_CONFIG;
  wire sel_ev  = reg_addr == erdaf_pkg::REG_EVENTS;
  wire sel_ptr = reg_addr == erdaf_pkg::REG_POINTERS;
  wire sel_bd  = reg_addr[erdaf_pkg::BD_SEL_BIT];
  wire [8:0] bus_word = reg_addr[8:0];

  // control fields
  wire       hash_mode         = ar_control[erdaf_pkg::AR_HASH_EN];
  wire       index_insert      = ar_control[erdaf_pkg::AR_INDEX_EN];
  wire [1:0] group_address_accept = ar_control[erdaf_pkg::AR_GROUP_HI:erdaf_pkg::AR_GROUP_LO];
  wire       individual_address_invert = ar_control[erdaf_pkg::AR_INVERT];
  wire       accept_all_frames = ar_control[erdaf_pkg::AR_ACCEPT_ALL];

  // table split: transmit gets 8 << split descriptors, receive the rest
  wire [7:0] tx_count = 8'h08 << descriptor_split;
  wire [6:0] tx_end   = 7'(tx_count - 8'h01);
  wire [6:0] rx_base  = tx_count[6:0];

  // address filtering
  wire line_is_hash  = hash_mode && (rx_table_line == erdaf_pkg::HASH_LINE_A ||
                                     rx_table_line == erdaf_pkg::HASH_LINE_B);
  wire perfect_match = rx_table_hit && !line_is_hash;
  wire hash_match    = hash_mode && rx_hash_hit;
  wire any_match     = perfect_match || hash_match;
  wire group_by_ctl  = (group_address_accept == erdaf_pkg::GROUP_ALL) ||
                       (group_address_accept == erdaf_pkg::GROUP_BROADCAST && rx_dest_broadcast) ||
                       (group_address_accept == erdaf_pkg::GROUP_MATCHED &&
                        (any_match || rx_dest_broadcast));
  wire indiv_ok      = individual_address_invert ? !perfect_match : any_match;
  wire addr_ok       = rx_dest_group ? group_by_ctl : indiv_ok;
  wire accept_now    = accept_all_frames || addr_ok;
  wire miss_now      = accept_all_frames && !addr_ok;
  wire [1:0] reason  = miss_now ? erdaf_pkg::REASON_MISS :
                       perfect_match ? erdaf_pkg::REASON_PERFECT :
                       hash_match ? erdaf_pkg::REASON_HASH : erdaf_pkg::REASON_GROUP;
  wire [5:0] index_now = perfect_match ? rx_table_line : rx_hash_index;

  // receive descriptor view
  wire [8:0]  rx_w0     = {rx_ptr, erdaf_pkg::W_STATUS};
  wire [8:0]  rx_w1     = {rx_ptr, erdaf_pkg::W_LENGTH};
  wire [8:0]  rx_w2     = {rx_ptr, erdaf_pkg::W_PTR_HI};
  wire [8:0]  rx_w3     = {rx_ptr, erdaf_pkg::W_PTR_LO};
  wire [15:0] rx_stat   = bd_ram[rx_w0];
  wire        rx_owned  = rx_stat[erdaf_pkg::BD_OWN];
  wire        rx_wrap   = rx_stat[erdaf_pkg::BD_WRAP] || rx_ptr == erdaf_pkg::BD_LAST;
  wire [6:0]  rx_ptr_nx = rx_wrap ? rx_base : 7'(rx_ptr + 7'h01);

  // transmit descriptor view
  wire [8:0]  tx_w0     = {tx_ptr, erdaf_pkg::W_STATUS};
  wire [15:0] tx_stat   = bd_ram[tx_w0];
  wire        tx_owned  = tx_stat[erdaf_pkg::BD_OWN];
  wire        tx_last   = tx_stat[erdaf_pkg::BD_LAST_BIT];
  wire        tx_wrap   = tx_stat[erdaf_pkg::BD_WRAP] || tx_ptr == tx_end;
  wire [6:0]  tx_ptr_nx = tx_wrap ? 7'h00 : 7'(tx_ptr + 7'h01);

  // receive sequencing
  wire open_ok   = mac_global_enable && rx_frame_start && accept_now;
  wire in_recv   = rx_state == ERDAF_RECV;
  wire close_buf = in_recv && rx_owned && rx_buf_full && !rx_frame_end && !rx_abort;
  wire close_frm = in_recv && rx_owned && (rx_frame_end || rx_abort);
  wire rx_close  = close_buf || close_frm;
  wire tx_close  = mac_global_enable && tx_owned && tx_buf_done;

  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      ERDAF_IDLE: begin
        if (open_ok) begin
          next_rx_state = rx_owned ? ERDAF_RECV : ERDAF_DROP;
        end
      end
      ERDAF_RECV: begin
        if (rx_frame_end || rx_abort) begin
          next_rx_state = ERDAF_IDLE;
        end
      end
      ERDAF_DROP: begin
        if (rx_frame_end || rx_abort) begin
          next_rx_state = ERDAF_IDLE;
        end
      end
      default: next_rx_state = ERDAF_IDLE;
    endcase
  end

  // status word for a closing receive descriptor
  wire        lg_now  = rx_frame_bytes > erdaf_pkg::MAX_RX_BYTES;
  wire        no_now  = rx_nonoctet && rx_crc_bad;
  wire        cr_now  = rx_crc_bad && !rx_nonoctet;
  logic [15:0] rx_done_stat;
  always_comb begin
    rx_done_stat = rx_stat & erdaf_pkg::RX_KEEP_MASK;
    rx_done_stat[erdaf_pkg::BD_FIRST] = rx_first;
    if (close_frm) begin
      rx_done_stat[erdaf_pkg::BD_LAST_BIT] = 1'b1;
      if (rx_fifo_overflow) begin
        rx_done_stat[erdaf_pkg::BD_OV] = 1'b1;
      end else begin
        rx_done_stat[erdaf_pkg::BD_MISS] = frame_miss;
        rx_done_stat[erdaf_pkg::BD_LG]   = lg_now;
        rx_done_stat[erdaf_pkg::BD_NO]   = no_now;
        rx_done_stat[erdaf_pkg::BD_SH]   = 1'b0;
        rx_done_stat[erdaf_pkg::BD_CR]   = cr_now;
        rx_done_stat[erdaf_pkg::BD_CL]   = rx_late_coll;
      end
    end
  end

  wire [15:0] tx_done_stat = (tx_stat & erdaf_pkg::TX_KEEP_MASK) |
                             ((tx_last && (tx_starved || tx_underrun)) ? 16'h0002 : 16'h0000);
  wire [15:0] rx_new_hi    = {frame_tag, bd_ram[rx_w2][7:0]};

  // descriptor memory: device closes words, software writes any word
  always_ff @(posedge mclk) begin
    if (reg_wr && sel_bd) begin
      bd_ram[bus_word] <= reg_wdata;
    end
    if (rx_close) begin
      bd_ram[rx_w0] <= rx_done_stat;
      bd_ram[rx_w1] <= rx_buf_len;
      if (index_insert) begin
        bd_ram[rx_w2] <= rx_new_hi;
      end
    end
    if (tx_close) begin
      bd_ram[tx_w0] <= tx_done_stat;
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      mac_global_enable <= 1'b0;
      ar_control        <= erdaf_pkg::AR_CONTROL_RESET;
      descriptor_split  <= erdaf_pkg::SPLIT_RESET;
    end else begin
      if (reg_wr && sel_ctl) begin
        mac_global_enable <= reg_wdata[0];
      end
      if (reg_wr && sel_ar && !mac_global_enable) begin
        ar_control <= reg_wdata & erdaf_pkg::AR_WRITABLE;
      end
      if (reg_wr && sel_dma && !mac_global_enable) begin
        descriptor_split <= reg_wdata[1:0];
      end
    end
  end

  // events: set wins over a write-one clear
  wire ev_busy = mac_global_enable && ((rx_data_avail && in_recv && !rx_owned) ||
                 (open_ok && !rx_owned && rx_state == ERDAF_IDLE));
  wire ev_rxb  = rx_close && rx_stat[erdaf_pkg::BD_IRQ];
  wire [erdaf_pkg::EV_WIDTH-1:0] ev_set = {tx_close && tx_stat[erdaf_pkg::BD_IRQ], close_frm, ev_rxb, ev_busy};
  wire [erdaf_pkg::EV_WIDTH-1:0] ev_clr = (reg_wr && sel_ev) ? reg_wdata[erdaf_pkg::EV_WIDTH-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      events <= '0;
    end else begin
      events <= (events & ~ev_clr) | ev_set;
    end
  end

  // descriptor pointers and frame state
  always_ff @(posedge mclk) begin
    if (rst || !mac_global_enable) begin
      tx_ptr     <= 7'h00;
      rx_ptr     <= 7'h00;
      rx_state   <= ERDAF_IDLE;
      rx_first   <= 1'b0;
      tx_starved <= 1'b0;
      frame_tag  <= 8'h00;
      frame_miss <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      if (rx_state == ERDAF_IDLE && rx_ptr < rx_base) begin
        rx_ptr <= rx_base;
      end else if (rx_close) begin
        rx_ptr <= rx_ptr_nx;
      end
      if (open_ok && rx_state == ERDAF_IDLE) begin
        rx_first   <= 1'b1;
        frame_tag  <= {reason, index_now};
        frame_miss <= miss_now;
      end else if (rx_close) begin
        rx_first <= 1'b0;
      end
      if (tx_close) begin
        tx_ptr <= tx_ptr_nx;
      end
      if (tx_close && tx_last) begin
        tx_starved <= 1'b0;
      end else if (tx_underrun) begin
        tx_starved <= 1'b1;
      end
    end
  end

  // read data, one cycle after the strobe
  wire [15:0] rd_mux = sel_bd  ? bd_ram[bus_word] :
                       sel_ctl ? {15'h0000, mac_global_enable} :
                       sel_ar  ? ar_control :
                       sel_dma ? {14'h0000, descriptor_split} :
                       sel_ev  ? {{(16-erdaf_pkg::EV_WIDTH){1'b0}}, events} :
                       sel_ptr ? {1'b0, rx_ptr, 1'b0, tx_ptr} : 16'h0000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // datapath toward the FIFOs and the bus
  assign rx_frame_accept = accept_now;
  assign rx_store_byte   = rx_frame_bytes < erdaf_pkg::MAX_RX_BYTES;
  assign rx_dma_ready    = mac_global_enable && in_recv && rx_owned;
  assign tx_dma_ready    = mac_global_enable && tx_owned;
  assign tx_bad_crc      = tx_starved || tx_underrun;

  // buffer addresses; receive buffers are even, so bit zero is dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_dma_addr <= 32'h00000000;
      tx_dma_addr <= 32'h00000000;
    end else begin
      rx_dma_addr <= {bd_ram[rx_w2], bd_ram[rx_w3][15:1], 1'b0};
      tx_dma_addr <= {bd_ram[{tx_ptr, erdaf_pkg::W_PTR_HI}], bd_ram[{tx_ptr, erdaf_pkg::W_PTR_LO}]};
    end
  end

endmodule : erdaf_core
`default_nettype wire

// ===== tb/erdaf_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module erdaf_mem_model (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic tx_dma_ready,
  output logic      tx_buf_done
);
  logic [3:0] wait_cnt;

  // a buffer fetch takes two or seven cycles; done is a one-cycle pulse
  always_ff @(posedge mclk) begin
    if (rst || !tx_dma_ready || tx_buf_done) begin
      wait_cnt    <= 4'h0;
      tx_buf_done <= 1'b0;
    end else begin
      wait_cnt    <= wait_cnt + 4'h1;
      tx_buf_done <= (wait_cnt == (slow ? 4'h6 : 4'h1));
    end
  end
endmodule : erdaf_mem_model

`default_nettype wire

// ===== tb/erdaf_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module erdaf_core_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [9:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        rx_dest_group,
  input wire logic        rx_dest_broadcast,
  input wire logic        rx_table_hit,
  input wire logic [10:0] rx_frame_bytes,
  input wire logic        rx_frame_accept,
  input wire logic        rx_store_byte,
  input wire logic        rx_dma_ready,
  input wire logic [31:0] rx_dma_addr,
  input wire logic        tx_underrun,
  input wire logic        tx_buf_done,
  input wire logic        tx_dma_ready,
  input wire logic        tx_bad_crc
);
  logic [15:0] ar;
  logic        en;
  logic        ar_rd;

  assign ar_rd = reg_rd && reg_addr == erdaf_pkg::REG_AR_CONTROL;

  // shadow of the enable and of the write-protected control word
  always_ff @(posedge mclk) begin
    if (rst) begin
      ar <= 16'h0000;
      en <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == erdaf_pkg::REG_CONTROL) en <= reg_wdata[0];
      if (reg_addr == erdaf_pkg::REG_AR_CONTROL && !en) ar <= reg_wdata & erdaf_pkg::AR_WRITABLE;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_AR_READBACK: assert property (ar_rd |=> reg_rdata == $past(ar))
    else $error("control word readback wrong");
  AST_AR_RESERVED: assert property (ar_rd |=> reg_rdata[9:0] == 10'h000)
    else $error("reserved control bits not zero");
  AST_STORE_LIMIT: assert property (rx_store_byte == (rx_frame_bytes < erdaf_pkg::MAX_RX_BYTES))
    else $error("store enable wrong for frame length");
  AST_ACCEPT_ALL: assert property (ar[erdaf_pkg::AR_ACCEPT_ALL] |-> rx_frame_accept)
    else $error("frame refused in accept-all mode");
  AST_INDIV_MATCH: assert property (!ar[10] && !rx_dest_group && rx_table_hit |-> rx_frame_accept == !ar[11])
    else $error("individual match decision wrong");
  AST_BCAST_BLOCK: assert property (!ar[10] && rx_dest_broadcast && ar[13:12] == 2'h0 |-> !rx_frame_accept)
    else $error("broadcast accepted with group reception off");
  AST_UNDERRUN_CRC: assert property (en && tx_underrun && !tx_buf_done |=> tx_bad_crc)
    else $error("bad checksum not requested after starve");
  AST_DISABLED_IDLE: assert property (!en |-> !tx_dma_ready && !rx_dma_ready)
    else $error("dma request while disabled");
  AST_EVEN_RX_ADDR: assert property (rx_dma_addr[0] == 1'b0)
    else $error("odd receive dma address");
  AST_OWN_AFTER_DMA: assert property (en && $fell(tx_dma_ready) |-> $past(tx_buf_done))
    else $error("transmit ownership dropped before dma done");
endmodule : erdaf_core_asserts

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam logic [9:0] a_ar = erdaf_pkg::REG_AR_CONTROL;
  localparam logic [9:0] a_ctl = erdaf_pkg::REG_CONTROL;
  localparam logic [9:0] a_ev = erdaf_pkg::REG_EVENTS;
  localparam logic [9:0] a_ptr = erdaf_pkg::REG_POINTERS;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  reg_addr = 10'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        fstart = 1'b0;
  logic        fend = 1'b0;
  logic [3:0]  fin = 4'h0;
  logic [3:0]  fl = 4'h0;
  logic [5:0]  line = 6'h00;
  logic [10:0] nbytes = 11'h000;
  logic [15:0] blen = 16'h0000;
  logic        tx_un = 1'b0;
  logic        slow = 1'b1;
  logic        zero = 1'b0;
  logic        accept;
  logic        tx_done;
  logic        tx_rdy;
  logic        bad_crc;
  logic        rd_d = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic [15:0] d;
  logic [15:0] ph;
  logic [10:0] ftab[12];
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #2.5 mclk = ~mclk;

  erdaf_core u_dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_frame_start(fstart), .rx_dest_group(fin[3]),
    .rx_dest_broadcast(fin[2]), .rx_table_hit(fin[1]), .rx_table_line(line), .rx_hash_hit(fin[0]),
    .rx_hash_index(line), .rx_data_avail(zero), .rx_frame_bytes(nbytes), .rx_buf_full(zero),
    .rx_buf_len(blen), .rx_frame_end(fend), .rx_abort(zero), .rx_nonoctet(fl[3]), .rx_crc_bad(fl[2]),
    .rx_late_coll(fl[1]), .rx_fifo_overflow(fl[0]), .rx_frame_accept(accept), .rx_store_byte(),
    .rx_dma_ready(), .rx_dma_addr(), .tx_buf_done(tx_done), .tx_underrun(tx_un),
    .tx_dma_ready(tx_rdy), .tx_dma_addr(), .tx_bad_crc(bad_crc)
  );

  erdaf_mem_model u_mem (
    .mclk(mclk), .rst(rst), .slow(slow), .tx_dma_ready(tx_rdy), .tx_buf_done(tx_done)
  );

  task automatic stop_test;
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic cmp_word(input logic [15:0] e, input logic [15:0] m, input logic [15:0] got);
    n_tests++;
    if ((got & m) !== (e & m)) begin
      n_fail++;
      $display("Error t=%0t exp=%h got=%h", $time, e & m, got & m);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic e, input logic got);
    n_tests++;
    if (got !== e) begin
      n_fail++;
      $display("Error t=%0t exp=%h got=%h", $time, e, got);
    end
  endtask : cmp_bit

  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge mclk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic rx_frame(input logic [3:0] f_in, input logic [3:0] flags, input logic [10:0] n);
    @(posedge mclk);
    fin <= f_in;
    line <= 6'($urandom);
    fstart <= 1'b1;
    @(posedge mclk);
    fstart <= 1'b0;
    @(posedge mclk);
    fl <= flags;
    nbytes <= n;
    blen <= 16'($urandom);
    fend <= 1'b1;
    @(posedge mclk);
    fend <= 1'b0;
    fl <= 4'h0;
    repeat (2) @(posedge mclk);
  endtask : rx_frame

  // read data stand in the cycle after the strobe
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    cyc++;
    if (rd_d) cmp_word(exp_q.pop_front(), msk_q.pop_front(), reg_rdata);
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(80));
    ftab = '{11'h005, 11'h000, 11'h044, 11'h041, 11'h403, 11'h002,
             11'h443, 11'h018, 11'h099, 11'h090, 11'h191, 11'h031};
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(a_ar, 16'h0000, 16'hffff);
    wr(10'h200, 16'h0000);
    d = 16'($urandom);
    wr(a_ar, d);
    rd(a_ar, d, erdaf_pkg::AR_WRITABLE);
    rd(a_ar, 16'h0000, 16'h03ff);
    wr(a_ctl, 16'h0001);
    wr(a_ar, ~d);
    rd(a_ar, d & erdaf_pkg::AR_WRITABLE, 16'hffff);
    wr(a_ctl, 16'h0000);
    foreach (ftab[i]) begin
      wr(a_ar, {ftab[i][10:5], 10'h000});
      fin <= ftab[i][4:1];
      @(posedge mclk);
      cmp_bit(ftab[i][0], accept);
    end
    ph = 16'($urandom);
    wr(10'h220, 16'hb000);
    wr(10'h222, ph);
    wr(10'h223, 16'($urandom) & 16'hfffe);
    wr(10'h200, 16'h8800);
    wr(10'h204, 16'h0000);
    wr(a_ar, 16'h4400);
    wr(a_ctl, 16'h0001);
    tx_un <= 1'b1;
    @(posedge mclk);
    tx_un <= 1'b0;
    @(posedge mclk);
    cmp_bit(1'b1, bad_crc);
    for (int i = 0; i < 30 && !tx_done; i++) @(posedge mclk);
    rd(10'h200, 16'h0802, 16'hffff);
    rd(a_ptr, 16'h0001, 16'h007f);
    rx_frame(4'h0, 4'h4, 11'd64);
    rd(10'h220, 16'h3d04, 16'hffff);
    rd(10'h221, blen, 16'hffff);
    rd(a_ev, 16'h0006, 16'h0006);
    rd(a_ptr, 16'h0800, 16'h7f00);
    wr(10'h220, 16'ha000);
    rx_frame(4'h2, 4'hf, 11'd64);
    rd(10'h220, 16'h2c02, 16'hffff);
    rd(10'h222, {erdaf_pkg::REASON_PERFECT, line, ph[7:0]}, 16'hffff);
    wr(10'h220, 16'ha000);
    rx_frame(4'h2, 4'he, 11'd1600);
    rd(10'h220, 16'h2c31, 16'hffff);
    wr(a_ev, 16'h000f);
    rx_frame(4'h2, 4'h0, 11'd64);
    rd(a_ev, 16'h0001, 16'h0001);
    rd(10'h220, 16'h2c31, 16'hffff);
    wr(a_ctl, 16'h0000);
    rd(a_ptr, 16'h0000, 16'h7f7f);
    rd(10'h200, 16'h0802, 16'hffff);
    repeat (3) @(posedge mclk);
    stop_test();
  end
endmodule : tb

bind erdaf_core erdaf_core_asserts u_chk (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_dest_group(rx_dest_group),
  .rx_dest_broadcast(rx_dest_broadcast), .rx_table_hit(rx_table_hit), .rx_frame_bytes(rx_frame_bytes),
  .rx_frame_accept(rx_frame_accept), .rx_store_byte(rx_store_byte), .rx_dma_ready(rx_dma_ready),
  .rx_dma_addr(rx_dma_addr), .tx_underrun(tx_underrun), .tx_buf_done(tx_buf_done),
  .tx_dma_ready(tx_dma_ready), .tx_bad_crc(tx_bad_crc)
);

`default_nettype wire
